// >>> ccf_pkg.sv
// Package: register map, reset values, states and carriers of the cache unit
package ccf_pkg;

   // Register port
   localparam int          REG_AW        = 8;
   localparam logic [7:0]  REG_REGION    = 8'h00;
   localparam logic [7:0]  REG_CTRL      = 8'h04;
   localparam logic [7:0]  REG_STATUS    = 8'h08;
   localparam logic [31:0] REGION_RST    = 32'h00000000;
   localparam logic        XLATE_RST     = 1'b0;
   localparam int          CTRL_XLATE    = 0;
   localparam int          STAT_FILL     = 0;
   localparam int          STAT_FLUSH    = 1;
   localparam int          STAT_FBVALID  = 2;
   localparam int          STAT_BUSERR   = 3;

   // Address layout
   localparam int          LINE_WORDS    = 8;
   localparam int          WIDX_W        = 3;
   localparam int          LINE_OFS_W    = 5;
   localparam int          LINE_BYTES    = 32;
   localparam int          REGION_MSB    = 31;
   localparam int          REGION_LSB    = 27;
   localparam int          IC_INDEX_MSB  = 12;
   localparam int          IC_INDEX_LSB  = 5;
   localparam int          IC_TAG_LSB    = 10;
   localparam logic [2:0]  LAST_WORD     = 3'h7;
   localparam logic [3:0]  ALL_BYTES     = 4'hF;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FILL_REQ,
      ST_FILL,
      ST_VICTIM,
      ST_COMMIT,
      ST_FLUSH
   } ccf_state_t;

   typedef struct packed {
      logic                 wr;
      logic                 rd;
      logic [REG_AW-1:0]    addr;
      logic [31:0]          wdata;
   } ccf_reg_req_t;

   typedef struct packed {
      logic                 valid;
      logic                 we;
      logic                 cachable;
      logic [3:0]           be;
      logic [31:0]          addr;
      logic [31:0]          wdata;
   } ccf_core_req_t;

   typedef struct packed {
      logic                 valid;
      logic                 err;
      logic [WIDX_W-1:0]    idx;
      logic [31:0]          data;
   } ccf_bus_word_t;

endpackage

// >>> ccf_line_mem.sv
// Line-wide data array with byte write enables and registered read
`timescale 1ns/1ps
module ccf_line_mem #(
   parameter int DEPTH = 128,
   parameter int BYTES = 32,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock
   input  wire logic                 mclk,
   // Read port
   input  wire logic                 rd_en,
   input  wire logic [AW-1:0]        rd_addr,
   output      logic [BYTES*8-1:0]   rd_data,
   // Write port
   input  wire logic                 wr_en,
   input  wire logic [AW-1:0]        wr_addr,
   input  wire logic [BYTES-1:0]     wr_be,
   input  wire logic [BYTES*8-1:0]   wr_data
);

   logic [BYTES*8-1:0] mem [DEPTH];

   // Per-byte enables: partial stores need no read-modify-write
   always_ff @(posedge mclk)
   begin
      if (wr_en)
      begin
         for (int b = 0; b < BYTES; b++)
         begin
            if (wr_be[b])
               mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
         end
      end
      if (rd_en)
         rd_data <= mem[rd_addr];
   end

endmodule // ccf_line_mem

// >>> ccf_cache_unit.sv
// Cache unit: fetch cachability, data line fill, replacement and flush
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module ccf_cache_unit #(
   parameter int SETS = 64
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst,
   // Register port
   input  wire ccf_pkg::ccf_reg_req_t reg_req,
   output      logic [31:0]          reg_rdata,
   // Instruction fetch attributes
   input  wire logic [31:0]          if_ea,
   input  wire logic [31:0]          if_ra,
   input  wire logic                 page_inhibit_attribute,
   output      logic                 instr_translate_enable,
   output      logic                 if_cachable,
   output      logic [7:0]           if_index,
   output      logic [21:0]          if_tag,
   // Core data access
   input  wire ccf_pkg::ccf_core_req_t core_req,
   output      logic                 core_ready,
   output      logic                 rsp_valid,
   output      logic [31:0]          rsp_data,
   // Bus line read
   output      logic                 bus_rd_req,
   output      logic [31:0]          bus_rd_addr,
   input  wire logic                 bus_rd_gnt,
   input  wire ccf_pkg::ccf_bus_word_t bus_rd,
   // Bus write
   output      logic                 bus_wr_valid,
   output      logic [31:0]          bus_wr_addr,
   output      logic [3:0]           bus_wr_be,
   output      logic [31:0]          bus_wr_data,
   output      logic                 bus_wr_last,
   input  wire logic                 bus_wr_ready,
   // Exception
   output      logic                 machine_check
);

   localparam int IDXW = $clog2(SETS);
   localparam int TAGW = 32 - ccf_pkg::LINE_OFS_W - IDXW;
   localparam int LAW  = 32 - ccf_pkg::LINE_OFS_W;
   localparam int MAW  = IDXW + 1;

   typedef struct packed {
      ccf_pkg::ccf_state_t          state;
      logic [31:0]                  region;
      logic                         xlate;
      logic                         ic_cach;
      logic [7:0]                   ic_index;
      logic [21:0]                  ic_tag;
      logic [31:0]                  reg_rdata;
      logic [SETS-1:0][1:0][TAGW-1:0] tag;
      logic [SETS-1:0][1:0]         valid;
      logic [SETS-1:0][1:0]         dirty;
      logic [SETS-1:0]              lru;
      logic [7:0][31:0]             fb_data;
      logic [7:0][3:0]              fb_merge;
      logic [7:0]                   fb_have;
      logic [LAW-1:0]               fb_addr;
      logic                         fb_valid;
      logic                         fb_cach;
      logic                         fb_err;
      logic                         fb_dirty;
      logic                         last_err;
      logic                         pend_ld;
      logic [2:0]                   pend_word;
      logic [3:0]                   pend_be;
      logic                         rsp_valid;
      logic [31:0]                  rsp_data;
      logic                         ld_arr;
      logic [2:0]                   ld_word;
      logic [3:0]                   ld_be;
      logic                         vway;
      logic                         vdirty;
      logic [7:0][31:0]             fl_buf;
      logic [LAW-1:0]               fl_addr;
      logic [2:0]                   fl_cnt;
      logic                         fl_single;
      logic [3:0]                   fl_be;
      logic                         mchk;
   } st_t;

   st_t s_r;
   st_t s_nxt;

   logic                         mrd_en;
   logic [MAW-1:0]               mrd_addr;
   logic [255:0]                 mrd_data;
   logic                         mwr_en;
   logic [MAW-1:0]               mwr_addr;
   logic [31:0]                  mwr_be;
   logic [255:0]                 mwr_data;

   // Select addressed lanes and shift them down to bit zero
   function automatic logic [31:0] ccf_align(input logic [31:0] w,
                                             input logic [3:0]  be);
      logic [31:0] m;
      m = w & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      if (be[0])
         return m;
      else if (be[1])
         return m >> 8;
      else if (be[2])
         return m >> 16;
      else
         return m >> 24;
   endfunction

   // Bytes with be set come from nw, the rest from old
   function automatic logic [31:0] ccf_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (nw & m) | (old & ~m);
   endfunction

   logic [IDXW-1:0]  c_set;
   logic [TAGW-1:0]  c_tag;
   logic [2:0]       c_word;
   logic             h0;
   logic             h1;
   logic             fb_line;
   logic             can_take;
   logic [IDXW-1:0]  f_set;
   logic             v_way;

   always_comb
   begin
      s_nxt = s_r;
      core_ready = 1'b0;
      mrd_en = 1'b0;
      mrd_addr = '0;
      mwr_en = 1'b0;
      mwr_addr = '0;
      mwr_be = '0;
      mwr_data = '0;
      s_nxt.mchk = 1'b0;
      s_nxt.rsp_valid = 1'b0;
      s_nxt.ld_arr = 1'b0;
      c_set = core_req.addr[IDXW+4:5];
      c_tag = core_req.addr[31:IDXW+5];
      c_word = core_req.addr[4:2];
      f_set = s_r.fb_addr[IDXW-1:0];
      h0 = s_r.valid[c_set][0] && s_r.tag[c_set][0] == c_tag;
      h1 = s_r.valid[c_set][1] && s_r.tag[c_set][1] == c_tag;
      fb_line = s_r.fb_valid && s_r.fb_addr == core_req.addr[31:5];
      can_take = !s_r.pend_ld && (s_r.state == ccf_pkg::ST_IDLE ||
                 s_r.state == ccf_pkg::ST_FILL_REQ ||
                 s_r.state == ccf_pkg::ST_FILL);
      if (!s_r.valid[f_set][0])
         v_way = 1'b0;
      else if (!s_r.valid[f_set][1])
         v_way = 1'b1;
      else
         v_way = s_r.lru[f_set];

      // Register port
      s_nxt.reg_rdata = '0;
      if (reg_req.rd)
      begin
         case (reg_req.addr)
            ccf_pkg::REG_REGION: s_nxt.reg_rdata = s_r.region;
            ccf_pkg::REG_CTRL:   s_nxt.reg_rdata[ccf_pkg::CTRL_XLATE] =
                                    s_r.xlate;
            ccf_pkg::REG_STATUS:
            begin
               s_nxt.reg_rdata[ccf_pkg::STAT_FILL] =
                  s_r.state == ccf_pkg::ST_FILL_REQ ||
                  s_r.state == ccf_pkg::ST_FILL;
               s_nxt.reg_rdata[ccf_pkg::STAT_FLUSH] =
                  s_r.state == ccf_pkg::ST_FLUSH;
               s_nxt.reg_rdata[ccf_pkg::STAT_FBVALID] = s_r.fb_valid;
               s_nxt.reg_rdata[ccf_pkg::STAT_BUSERR] = s_r.last_err;
            end
            default: s_nxt.reg_rdata = '0;
         endcase
      end
      if (reg_req.wr && reg_req.addr == ccf_pkg::REG_REGION)
         s_nxt.region = reg_req.wdata;
      if (reg_req.wr && reg_req.addr == ccf_pkg::REG_CTRL)
         s_nxt.xlate = reg_req.wdata[ccf_pkg::CTRL_XLATE];

      // Fetch side works from its own inputs and the region and xlate registers, nothing is snooped
      if (s_r.xlate)
         s_nxt.ic_cach = !page_inhibit_attribute;
      else
         s_nxt.ic_cach = s_r.region[if_ea[ccf_pkg::REGION_MSB:
                                          ccf_pkg::REGION_LSB]];
      s_nxt.ic_index = if_ea[ccf_pkg::IC_INDEX_MSB:ccf_pkg::IC_INDEX_LSB];
      s_nxt.ic_tag = if_ra[31:ccf_pkg::IC_TAG_LSB];

      // Returning fill words, taken in whatever order they come
      if ((s_r.state == ccf_pkg::ST_FILL_REQ ||
           s_r.state == ccf_pkg::ST_FILL) && bus_rd.valid)
      begin
         s_nxt.fb_data[bus_rd.idx] = ccf_merge(bus_rd.data,
            s_r.fb_data[bus_rd.idx], s_r.fb_merge[bus_rd.idx]);
         s_nxt.fb_have[bus_rd.idx] = 1'b1;
         if (bus_rd.err)
            s_nxt.fb_err = 1'b1;
         if (s_r.pend_ld && bus_rd.idx == s_r.pend_word)
         begin
            s_nxt.pend_ld = 1'b0;
            s_nxt.rsp_valid = 1'b1;
            s_nxt.rsp_data = ccf_align(bus_rd.data, s_r.pend_be);
         end
      end

      // Core access
      if (core_req.valid && can_take)
      begin
         if (fb_line && !core_req.we && s_r.fb_have[c_word])
         begin
            core_ready = 1'b1;
            s_nxt.rsp_valid = 1'b1;
            s_nxt.rsp_data = ccf_align(s_r.fb_data[c_word],
                                       core_req.be);
         end
         else if (fb_line && s_r.fb_cach && core_req.cachable)
         begin
            if (core_req.we)
            begin
               core_ready = 1'b1;
               s_nxt.fb_data[c_word] = ccf_merge(s_nxt.fb_data[c_word],
                  core_req.wdata, core_req.be);
               s_nxt.fb_merge[c_word] = s_r.fb_merge[c_word] | core_req.be;
               s_nxt.fb_dirty = 1'b1;
            end
         end
         else if (core_req.cachable && (h0 || h1))
         begin
            core_ready = 1'b1;
            s_nxt.lru[c_set] = h0;
            if (core_req.we)
            begin
               mwr_en = 1'b1;
               mwr_addr = {c_set, h1};
               mwr_be = 32'(core_req.be) << {c_word, 2'b00};
               mwr_data = {8{core_req.wdata}};
               s_nxt.dirty[c_set][h1] = 1'b1;
            end
            else
            begin
               mrd_en = 1'b1;
               mrd_addr = {c_set, h1};
               s_nxt.ld_arr = 1'b1;
               s_nxt.ld_word = c_word;
               s_nxt.ld_be = core_req.be;
            end
         end
         else if (!core_req.cachable && core_req.we)
         begin
            // Uncached store leaves as one word; a stale buffer copy dies
            if (s_r.state == ccf_pkg::ST_IDLE)
            begin
               core_ready = 1'b1;
               if (fb_line)
                  s_nxt.fb_valid = 1'b0;
               s_nxt.fl_addr = core_req.addr[31:5];
               s_nxt.fl_cnt = c_word;
               s_nxt.fl_buf[c_word] = core_req.wdata;
               s_nxt.fl_be = core_req.be;
               s_nxt.fl_single = 1'b1;
               s_nxt.state = ccf_pkg::ST_FLUSH;
            end
         end
         else if (s_r.state == ccf_pkg::ST_IDLE)
         begin
            // Miss or uncached load: open a new line in the buffer
            core_ready = 1'b1;
            s_nxt.fb_valid = 1'b1;
            s_nxt.fb_cach = core_req.cachable;
            s_nxt.fb_addr = core_req.addr[31:5];
            s_nxt.fb_have = '0;
            s_nxt.fb_merge = '0;
            s_nxt.fb_err = 1'b0;
            s_nxt.fb_dirty = core_req.we;
            s_nxt.state = ccf_pkg::ST_FILL_REQ;
            if (core_req.we)
            begin
               s_nxt.fb_data[c_word] = core_req.wdata;
               s_nxt.fb_merge[c_word] = core_req.be;
            end
            else
            begin
               s_nxt.pend_ld = 1'b1;
               s_nxt.pend_word = c_word;
               s_nxt.pend_be = core_req.be;
            end
         end
      end

      case (s_r.state)
         ccf_pkg::ST_IDLE:
         begin
         end
         ccf_pkg::ST_FILL_REQ, ccf_pkg::ST_FILL:
         begin
            if (s_r.state == ccf_pkg::ST_FILL_REQ && bus_rd_gnt)
               s_nxt.state = ccf_pkg::ST_FILL;
            // All eight words are waited for, error or not
            if (&s_nxt.fb_have)
            begin
               s_nxt.mchk = s_nxt.fb_err;
               s_nxt.last_err = s_nxt.fb_err;
               s_nxt.state = s_r.fb_cach ? ccf_pkg::ST_VICTIM :
                                           ccf_pkg::ST_IDLE;
            end
         end
         ccf_pkg::ST_VICTIM:
         begin
            s_nxt.vway = v_way;
            s_nxt.vdirty = s_r.valid[f_set][v_way] &&
                           s_r.dirty[f_set][v_way];
            mrd_en = 1'b1;
            mrd_addr = {f_set, v_way};
            s_nxt.state = ccf_pkg::ST_COMMIT;
         end
         ccf_pkg::ST_COMMIT:
         begin
            s_nxt.fl_buf = mrd_data;
            s_nxt.fl_addr = {s_r.tag[f_set][s_r.vway], f_set};
            mwr_en = 1'b1;
            mwr_addr = {f_set, s_r.vway};
            mwr_be = '1;
            mwr_data = s_r.fb_data;
            s_nxt.tag[f_set][s_r.vway] = s_r.fb_addr[LAW-1:IDXW];
            s_nxt.valid[f_set][s_r.vway] = 1'b1;
            s_nxt.dirty[f_set][s_r.vway] = s_r.fb_dirty;
            s_nxt.lru[f_set] = !s_r.vway;
            s_nxt.fb_valid = 1'b0;
            s_nxt.fl_cnt = '0;
            s_nxt.fl_single = 1'b0;
            s_nxt.fl_be = ccf_pkg::ALL_BYTES;
            s_nxt.state = s_r.vdirty ? ccf_pkg::ST_FLUSH :
                                       ccf_pkg::ST_IDLE;
         end
         ccf_pkg::ST_FLUSH:
         begin
            if (bus_wr_ready)
            begin
               if (s_r.fl_single || s_r.fl_cnt == ccf_pkg::LAST_WORD)
                  s_nxt.state = ccf_pkg::ST_IDLE;
               else
                  s_nxt.fl_cnt = s_r.fl_cnt + 3'h1;
            end
         end
         default: s_nxt.state = ccf_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.region <= ccf_pkg::REGION_RST;
         s_r.xlate <= ccf_pkg::XLATE_RST;
      end
      else
         s_r <= s_nxt;
   end

   ccf_line_mem #(
      .DEPTH (2 * SETS),
      .BYTES (ccf_pkg::LINE_BYTES),
      .AW    (MAW)
   ) u_mem (
      .mclk    (mclk),
      .rd_en   (mrd_en),
      .rd_addr (mrd_addr),
      .rd_data (mrd_data),
      .wr_en   (mwr_en),
      .wr_addr (mwr_addr),
      .wr_be   (mwr_be),
      .wr_data (mwr_data)
   );

   // Array hits return straight from the array's read register
   assign rsp_valid = s_r.rsp_valid || s_r.ld_arr;
   assign rsp_data = s_r.ld_arr ?
                     ccf_align(mrd_data[s_r.ld_word*32 +: 32], s_r.ld_be) :
                     s_r.rsp_data;
   assign reg_rdata = s_r.reg_rdata;
   assign instr_translate_enable = s_r.xlate;
   assign if_cachable = s_r.ic_cach;
   assign if_index = s_r.ic_index;
   assign if_tag = s_r.ic_tag;
   assign bus_rd_req = s_r.state == ccf_pkg::ST_FILL_REQ;
   assign bus_rd_addr = {s_r.fb_addr, 5'h00};
   assign bus_wr_valid = s_r.state == ccf_pkg::ST_FLUSH;
   assign bus_wr_addr = {s_r.fl_addr, s_r.fl_cnt, 2'h0};
   assign bus_wr_be = s_r.fl_be;
   assign bus_wr_data = s_r.fl_buf[s_r.fl_cnt];
   assign bus_wr_last = bus_wr_valid &&
                        (s_r.fl_single || s_r.fl_cnt == ccf_pkg::LAST_WORD);
   assign machine_check = s_r.mchk;

endmodule // ccf_cache_unit

// >>> ccf_cache_unit_props.sv
// Checker of the cache unit port behaviour
`timescale 1ns/1ps
module ccf_cache_unit_props (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // Fetch attributes
   input wire logic [31:0] if_ea,
   input wire logic [31:0] if_ra,
   input wire logic        page_inhibit_attribute,
   input wire logic        instr_translate_enable,
   input wire logic        if_cachable,
   input wire logic [7:0]  if_index,
   input wire logic [21:0] if_tag,
   // Core and bus
   input wire logic        core_ready,
   input wire logic        bus_rd_req,
   input wire logic [31:0] bus_rd_addr,
   input wire logic        bus_rd_gnt,
   input wire logic        bus_wr_valid,
   input wire logic [31:0] bus_wr_addr,
   input wire logic [3:0]  bus_wr_be,
   input wire logic        bus_wr_last,
   input wire logic        bus_wr_ready,
   input wire logic        machine_check
);
   logic [2:0]  beat_r;
   logic [31:0] ea_q, ra_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // A single store beat leaves the count at zero
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         beat_r <= 3'h0;
      else if (bus_wr_valid && bus_wr_ready)
         beat_r <= bus_wr_last ? 3'h0 : beat_r + 3'h1;
   always_ff @(posedge mclk)
   begin
      ea_q <= if_ea;
      ra_q <= if_ra;
   end
   sequence wr_wait_s;
      bus_wr_valid && !bus_wr_ready;
   endsequence
   sequence flush_beat_s;
      bus_wr_valid && !bus_wr_last;
   endsequence
   rd_align_a: assert property (bus_rd_req |->
      bus_rd_addr[4:0] == 5'h00) else $error("fill address not aligned");
   rd_hold_a: assert property (bus_rd_req && !bus_rd_gnt |=>
      bus_rd_req && $stable(bus_rd_addr)) else $error("fill request dropped");
   wr_hold_a: assert property (wr_wait_s |=> bus_wr_valid &&
      $stable(bus_wr_addr) && $stable(bus_wr_last)) else $error("beat moved");
   flush_order_a: assert property (flush_beat_s |->
      bus_wr_addr[4:2] == beat_r && bus_wr_be == 4'hF)
      else $error("flush word out of order");
   flush_end_a: assert property (bus_wr_valid && bus_wr_last &&
      beat_r != 3'h0 |-> beat_r == 3'h7 && bus_wr_addr[4:2] == 3'h7)
      else $error("flush ended early");
   flush_stall_a: assert property (flush_beat_s |->
      !core_ready && !bus_rd_req) else $error("core served during flush");
   mc_pulse_a: assert property (machine_check |=> !machine_check)
      else $error("machine check too long");
   xlate_on_a: assert property (instr_translate_enable |=>
      if_cachable == !$past(page_inhibit_attribute))
      else $error("page attribute ignored");
   idx_tag_a: assert property (!$past(rst) |->
      if_index == ea_q[12:5] && if_tag == ra_q[31:10])
      else $error("fetch index or tag wrong");
endmodule // ccf_cache_unit_props

bind ccf_cache_unit ccf_cache_unit_props u_props (.*);

// >>> ccf_bus_model.sv
// Bus slave and memory model facing the cache unit
`timescale 1ns/1ps
module ccf_bus_model (
   // Clock and reset
   input wire logic               mclk,
   input wire logic               rst,
   // Test controls
   input wire logic [1:0]         order_sel,
   input wire logic               err_en,
   input wire logic [2:0]         tgt,
   // Line read
   input wire logic               bus_rd_req,
   input wire logic [31:0]        bus_rd_addr,
   output     logic               bus_rd_gnt,
   output     ccf_pkg::ccf_bus_word_t bus_rd,
   // Write
   input wire logic               bus_wr_valid,
   input wire logic [31:0]        bus_wr_addr,
   input wire logic [3:0]         bus_wr_be,
   input wire logic [31:0]        bus_wr_data,
   output     logic               bus_wr_ready
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] base, w;
   logic [2:0]  idx, t;
   logic [1:0]  ord;
   logic        er;
   function automatic logic [31:0] rd_word(input logic [31:0] a);
      return mem.exists(a) ? mem[a] : a ^ 32'h5A3C96E1;
   endfunction
   initial
   begin
      bus_rd_gnt = 1'b0;
      bus_rd = '0;
      bus_wr_ready = 1'b0;
   end
   always @(posedge mclk)
   begin
      if (bus_wr_valid && bus_wr_ready)
      begin
         w = rd_word({bus_wr_addr[31:2], 2'h0});
         for (int b = 0; b < 4; b++)
            if (bus_wr_be[b])
               w[b*8+:8] = bus_wr_data[b*8+:8];
         mem[{bus_wr_addr[31:2], 2'h0}] = w;
      end
      bus_wr_ready <= 1'($urandom_range(1));
   end
   // Order latched at grant, so no word repeats
   always
   begin
      @(posedge mclk);
      if (!rst && bus_rd_req)
      begin
         repeat ($urandom_range(2)) @(posedge mclk);
         base = bus_rd_addr;
         ord = order_sel;
         t = tgt;
         er = err_en;
         bus_rd_gnt <= 1'b1;
         @(posedge mclk);
         bus_rd_gnt <= 1'b0;
         for (int i = 0; i < 8; i++)
         begin
            idx = ord == 2'h0 ? 3'(i) : 3'(7 - i);
            if (ord == 2'h1)
               idx = t + 3'(i);
            w = rd_word(base + {idx, 2'h0});
            bus_rd <= '{1'b1, er && idx == 3'h5, idx, w};
            @(posedge mclk);
            if ($urandom_range(1) == 1 || i == 7)
            begin
               bus_rd <= '{1'b0, 1'b0, ~idx, ~bus_rd.data};
               @(posedge mclk);
            end
         end
      end
   end
endmodule // ccf_bus_model

// >>> ccf_cache_unit_test.sv
// Self-checking bench of the cache unit
`timescale 1ns/1ps
module ccf_cache_unit_test;
   logic                   mclk = 1'b0, rst, page_inhibit_attribute;
   ccf_pkg::ccf_reg_req_t  reg_req;
   ccf_pkg::ccf_core_req_t core_req;
   ccf_pkg::ccf_bus_word_t bus_rd;
   logic [31:0]            reg_rdata, if_ea, if_ra, rsp_data, bus_rd_addr;
   logic [31:0]            bus_wr_addr, bus_wr_data, a, rv, v;
   logic                   if_cachable, core_ready, rsp_valid, bus_rd_req;
   logic                   instr_translate_enable, bus_rd_gnt, bus_wr_valid;
   logic                   bus_wr_last, bus_wr_ready, machine_check, p;
   logic [7:0]             if_index;
   logic [21:0]            if_tag;
   logic [3:0]             bus_wr_be, be;
   logic [3:0]             bes [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
   logic [1:0]             order_sel;
   logic [2:0]             tgt;
   logic                   err_en;
   logic [31:0]            sh [logic [31:0]];
   int failures = 0, checks_done = 0, mc_cnt = 0, fill_cnt = 0, f, n;

   ccf_cache_unit dut (.*);
   ccf_bus_model u_mem (.*);

   always #10 mclk = ~mclk;
   always @(posedge mclk)
   begin
      mc_cnt += int'(machine_check === 1'b1);
      fill_cnt += int'(bus_rd_gnt === 1'b1);
   end
   function automatic logic [31:0] mem_word(input logic [31:0] wa);
      return sh.exists(wa) ? sh[wa] : wa ^ 32'h5A3C96E1;
   endfunction
   // Only the addressed lanes, shifted down to bit 0
   function automatic logic [31:0] lane(input logic [31:0] w,
                                        input logic [3:0]  m);
      w &= {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
      return w >> (m[0] ? 0 : m[1] ? 8 : m[2] ? 16 : 24);
   endfunction
   task automatic check(input logic [31:0] got, exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic conclude;
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] ra, input logic [31:0] d);
      reg_req <= '{1'b1, 1'b0, ra, d};
      @(posedge mclk);
      reg_req <= '0;
      @(posedge mclk);
   endtask
   task automatic reg_rd(input logic [7:0] ra, output logic [31:0] d);
      reg_req <= '{1'b0, 1'b1, ra, 32'h0};
      @(posedge mclk);
      reg_req <= '0;
      @(posedge mclk);
      d = reg_rdata;
   endtask
   task automatic fetch(input logic [31:0] ea, input logic pia, exp);
      if_ea <= ea;
      if_ra <= ~ea;
      page_inhibit_attribute <= pia;
      repeat (2) @(posedge mclk);
      check({31'h0, if_cachable}, {31'h0, exp}, "cachable");
      check({if_index, if_tag}, {ea[12:5], ~ea[31:10]}, "tag");
   endtask
   task automatic access(input logic we, c, input logic [3:0] m,
                         input logic [31:0] ad, d);
      logic [31:0] w;
      core_req <= '{1'b1, we, c, m, ad, d};
      for (int k = 0; k < 500 && core_ready !== 1'b1; k++)
         @(posedge mclk);
      core_req.valid <= 1'b0;
      w = mem_word({ad[31:2], 2'h0});
      for (int b = 0; b < 4; b++)
         if (we && m[b])
            w[b*8+:8] = d[b*8+:8];
      if (we)
         sh[{ad[31:2], 2'h0}] = w;
      for (int k = 0; !we && k < 500 && rsp_valid !== 1'b1; k++)
         @(posedge mclk);
      if (!we)
         check(rsp_data, lane(w, m), "load");
      @(posedge mclk);
   endtask
   initial
   begin
      #1_500_000;
      failures++;
      conclude();
   end
   initial
   begin
      {rst, reg_req, if_ea, if_ra, page_inhibit_attribute, core_req} = '1;
      {reg_req, core_req, order_sel, err_en, tgt} = '0;
      void'($urandom(83));
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      reg_rd(ccf_pkg::REG_REGION, v);
      check(v, 32'h0, "region reset");
      reg_rd(8'h0C, v);
      check(v, 32'h0, "unmapped read");
      fetch($urandom, 1'b0, 1'b0);
      // Cache is empty after reset, so regions may be enabled now
      rv = $urandom;
      reg_wr(ccf_pkg::REG_REGION, rv);
      for (int i = 0; i < 32; i++)
      begin
         a = {5'(i), 27'($urandom)};
         fetch(a, 1'($urandom), rv[a[31:27]]);
      end
      reg_wr(ccf_pkg::REG_CTRL, 32'h1);
      // No fetch page is ever remapped, so no alias purge is due
      for (int i = 0; i < 8; i++)
      begin
         p = 1'($urandom);
         fetch($urandom, p, !p);
      end
      reg_wr(ccf_pkg::REG_CTRL, 32'h0);
      order_sel <= 2'h1;
      tgt <= 3'h5;
      access(1'b0, 1'b1, 4'hF, 32'h00001014, 32'h0);
      access(1'b1, 1'b1, 4'h2, 32'h00001000, $urandom);
      access(1'b0, 1'b1, 4'hF, 32'h00001000, 32'h0);
      order_sel <= 2'h2;
      err_en <= 1'b1;
      access(1'b0, 1'b1, 4'hC, 32'h00002008, 32'h0);
      for (n = 0; n < 200 && mc_cnt == 0; n++)
         @(posedge mclk);
      err_en <= 1'b0;
      reg_rd(ccf_pkg::REG_STATUS, v);
      check(v & 32'h8, 32'h8, "bus error flag");
      check(32'(mc_cnt), 32'h1, "machine check");
      f = fill_cnt;
      access(1'b0, 1'b1, 4'hF, 32'h0000201C, 32'h0);
      check(32'(fill_cnt), 32'(f), "refill");
      access(1'b1, 1'b0, 4'h8, 32'h08000040, $urandom);
      access(1'b0, 1'b0, 4'hF, 32'h08000040, 32'h0);
      // Four tags over two sets force dirty evictions
      for (int i = 0; i < 300; i++)
      begin
         a = 32'h10000 * $urandom_range(3) + 32'h20 * $urandom_range(1);
         a = a + 32'h4 * $urandom_range(7);
         order_sel <= 2'($urandom_range(2));
         tgt <= a[4:2];
         be = bes[$urandom_range(6)];
         access(1'($urandom), 1'b1, be, a, $urandom);
      end
      conclude();
   end
endmodule // ccf_cache_unit_test
